// *** hw/alarm_pkg.sv ***
// constants for the spectral alarm trigger and status block
package alarm_pkg;
   localparam int NUM_AXES = 2;
   localparam int NUM_BANDS = 6;
   localparam int LEVEL_W = 16;
   localparam int BIN_W = 8;
   // register byte addresses
   localparam logic [7:0] ADDR_X_WARN = 8'h24;
   localparam logic [7:0] ADDR_Y_WARN = 8'h26;
   localparam logic [7:0] ADDR_X_CRIT = 8'h28;
   localparam logic [7:0] ADDR_Y_CRIT = 8'h2a;
   localparam logic [7:0] ADDR_SYS_LEVEL = 8'h2e;
   localparam logic [7:0] ADDR_ALARM_CTRL = 8'h30;
   localparam logic [7:0] ADDR_DIAG = 8'h34;
   localparam logic [7:0] ADDR_GLOBAL_CMD = 8'h36;
   localparam logic [7:0] ADDR_X_STATUS = 8'h38;
   localparam logic [7:0] ADDR_Y_STATUS = 8'h3a;
   localparam logic [7:0] ADDR_X_PEAK = 8'h3c;
   localparam logic [7:0] ADDR_Y_PEAK = 8'h3e;
   localparam logic [7:0] ADDR_X_BIN = 8'h44;
   localparam logic [7:0] ADDR_Y_BIN = 8'h46;
   localparam logic [7:0] ADDR_OUT_SELECT = 8'h60;
   // reset values and alarm control write mask
   localparam logic [15:0] LEVEL_RESET = 16'h0000;
   localparam logic [15:0] ALARM_CTRL_RESET = 16'h0080;
   localparam logic [15:0] ALARM_CTRL_MASK = 16'h0ffb;
   localparam logic [5:0] OUT_SELECT_RESET = 6'h00;
   // alarm control fields
   localparam int CTRL_X_EN = 0;
   localparam int CTRL_Y_EN = 1;
   localparam int CTRL_SYS_EN = 3;
   localparam int CTRL_SYS_TEMP = 4;
   localparam int CTRL_SYS_BELOW = 5;
   localparam int CTRL_DO_ALARM = 6;
   localparam int CTRL_LATCH = 7;
   localparam int CTRL_DELAY_LO = 8;
   localparam int CTRL_DELAY_HI = 11;
   // global command bits
   localparam int CMD_CLEAR_STATUS = 4;
   localparam int CMD_ALARM_CLEAR = 9;
   localparam int CMD_ALARM_SAVE = 12;
   // diagnostic flag positions and flag count
   localparam int DIAG_SYS = 0;
   localparam int DIAG_X_SPECTRAL = 1;
   localparam int DIAG_Y_SPECTRAL = 2;
   localparam int DIAG_SAVE_DROPPED = 3;
   localparam int DIAG_FLAGS = 4;
   // output select fields
   localparam int SEL_DO1_ALARM = 0;
   localparam int SEL_DO2_ALARM = 1;
   // status word layout and response delay limit
   localparam int STAT_BAND_BASE = 4;
   localparam int STAT_MOST_W = 3;
   localparam logic [3:0] DELAY_MAX = 4'hf;
endpackage

// *** hw/alarm_band_eval.sv ***
// one band of one axis: exceedance per record and response delay
`timescale 1ns/1ps
module alarm_band_eval (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic restart,
   input wire logic enable,
   input wire logic record_start,
   input wire logic record_end,
   input wire logic bin_hit,
   input wire logic [7:0] bin_index,
   input wire logic [15:0] bin_mag,
   input wire logic [7:0] low_bin,
   input wire logic [7:0] high_bin,
   input wire logic [15:0] warn_level,
   input wire logic [15:0] crit_level,
   input wire logic [3:0] delay,
   output logic warn_flag,
   output logic crit_flag
);
   logic in_band;
   logic seen_warn;
   logic seen_crit;
   logic [3:0] count_warn;
   logic [3:0] count_crit;

   assign in_band = bin_hit && enable && bin_index >= low_bin && bin_index <= high_bin;

   // exceedance seen in the current record
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         seen_warn <= 1'b0;
         seen_crit <= 1'b0;
      end else if (restart || record_start) begin
         seen_warn <= 1'b0;
         seen_crit <= 1'b0;
      end else if (in_band) begin
         seen_warn <= seen_warn || (bin_mag > warn_level);
         seen_crit <= seen_crit || (bin_mag > crit_level);
      end
   end

   // flag set once exceedance held for delay + 1 consecutive records, dropped on a clean record
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         count_warn <= 4'h0;
         count_crit <= 4'h0;
         warn_flag <= 1'b0;
         crit_flag <= 1'b0;
      end else if (restart) begin
         count_warn <= 4'h0;
         count_crit <= 4'h0;
         warn_flag <= 1'b0;
         crit_flag <= 1'b0;
      end else if (record_end) begin
         if (enable && seen_warn) begin
            warn_flag <= (count_warn >= delay);
            if (count_warn != alarm_pkg::DELAY_MAX) begin
               count_warn <= count_warn + 4'h1;
            end
         end else begin
            count_warn <= 4'h0;
            warn_flag <= 1'b0;
         end
         if (enable && seen_crit) begin
            crit_flag <= (count_crit >= delay);
            if (count_crit != alarm_pkg::DELAY_MAX) begin
               count_crit <= count_crit + 4'h1;
            end
         end else begin
            count_crit <= 4'h0;
            crit_flag <= 1'b0;
         end
      end
   end
endmodule

// *** hw/spectral_alarm_trigger_status.sv ***
// spectral alarm trigger levels, band status, system alarm and alarm outputs
`timescale 1ns/1ps
module spectral_alarm_trigger_status (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [15:0] reg_wdata,
   input wire logic [1:0] record_mode,
   input wire logic [1:0] record_range,
   input wire logic [1:0] active_rate,
   input wire logic [47:0] band_low_bins,
   input wire logic [47:0] band_high_bins,
   input wire logic record_start,
   input wire logic record_end,
   input wire logic bin_valid,
   input wire logic bin_axis,
   input wire logic [1:0] bin_rate,
   input wire logic [7:0] bin_index,
   input wire logic [15:0] bin_mag,
   input wire logic meas_valid,
   input wire logic [15:0] temperature,
   input wire logic [15:0] supply_voltage,
   output logic [15:0] reg_rdata,
   output logic first_digital_output,
   output logic second_digital_output,
   output logic save_request,
   output logic header_strobe,
   output logic [3:0] diagnostic_error_flags,
   output logic [15:0] x_band_alarm_status,
   output logic [15:0] y_band_alarm_status,
   output logic [15:0] x_axis_peak_magnitude,
   output logic [15:0] y_axis_peak_magnitude,
   output logic [7:0] x_axis_peak_bin,
   output logic [7:0] y_axis_peak_bin
);
   logic [15:0] x_warning_trigger_level;
   logic [15:0] y_warning_trigger_level;
   logic [15:0] x_critical_trigger_level;
   logic [15:0] y_critical_trigger_level;
   logic [15:0] system_trigger_level;
   logic [15:0] alarm_control_register;
   logic [5:0] output_select_control;
   logic storage_written;
   logic [1:0] last_mode;
   logic [1:0] last_range;
   logic format_change;
   logic sys_live;
   logic record_end_d;
   logic [1:0] run_valid;
   logic [15:0] run_peak [2];
   logic [7:0] run_bin [2];
   logic [5:0] warn_flags [2];
   logic [5:0] crit_flags [2];
   logic [15:0] next_status [2];
   logic cmd_wr;
   logic clear_cmd;
   logic save_cmd;
   logic clear_status_cmd;
   logic rate_ok;
   logic band_restart;
   logic [15:0] sys_meas;
   logic sys_trip;
   logic [3:0] diag_event;

   assign cmd_wr = reg_wr && reg_addr == alarm_pkg::ADDR_GLOBAL_CMD;
   assign clear_cmd = cmd_wr && reg_wdata[alarm_pkg::CMD_ALARM_CLEAR];
   assign save_cmd = cmd_wr && reg_wdata[alarm_pkg::CMD_ALARM_SAVE];
   assign clear_status_cmd = cmd_wr && reg_wdata[alarm_pkg::CMD_CLEAR_STATUS];
   assign rate_ok = bin_valid && bin_rate == active_rate;
   assign format_change = last_mode != record_mode || last_range != record_range;
   assign band_restart = clear_cmd || format_change;

   // trigger levels and control registers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         x_warning_trigger_level <= alarm_pkg::LEVEL_RESET;
         y_warning_trigger_level <= alarm_pkg::LEVEL_RESET;
         x_critical_trigger_level <= alarm_pkg::LEVEL_RESET;
         y_critical_trigger_level <= alarm_pkg::LEVEL_RESET;
         system_trigger_level <= alarm_pkg::LEVEL_RESET;
         alarm_control_register <= alarm_pkg::ALARM_CTRL_RESET;
         output_select_control <= alarm_pkg::OUT_SELECT_RESET;
      end else if (clear_cmd) begin
         x_warning_trigger_level <= alarm_pkg::LEVEL_RESET;
         y_warning_trigger_level <= alarm_pkg::LEVEL_RESET;
         x_critical_trigger_level <= alarm_pkg::LEVEL_RESET;
         y_critical_trigger_level <= alarm_pkg::LEVEL_RESET;
      end else if (reg_wr) begin
         unique case (reg_addr)
            alarm_pkg::ADDR_X_WARN: x_warning_trigger_level <= reg_wdata;
            alarm_pkg::ADDR_Y_WARN: y_warning_trigger_level <= reg_wdata;
            alarm_pkg::ADDR_X_CRIT: x_critical_trigger_level <= reg_wdata;
            alarm_pkg::ADDR_Y_CRIT: y_critical_trigger_level <= reg_wdata;
            alarm_pkg::ADDR_SYS_LEVEL: system_trigger_level <= reg_wdata;
            alarm_pkg::ADDR_ALARM_CTRL: alarm_control_register <=
               reg_wdata & alarm_pkg::ALARM_CTRL_MASK;
            alarm_pkg::ADDR_OUT_SELECT: output_select_control <= reg_wdata[5:0];
            default: ;
         endcase
      end
   end

   // persistent store request; a second save before a clear is dropped
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         storage_written <= 1'b0;
         save_request <= 1'b0;
      end else begin
         save_request <= save_cmd && !clear_cmd && !storage_written;
         if (clear_cmd) begin
            storage_written <= 1'b0;
         end else if (save_cmd) begin
            storage_written <= 1'b1;
         end
      end
   end

   // format tracking: a new range or mode restarts the band evaluation
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         last_mode <= 2'h0;
         last_range <= 2'h0;
      end else begin
         last_mode <= record_mode;
         last_range <= record_range;
      end
   end

   // band evaluators, one per axis and band
   for (genvar a = 0; a < alarm_pkg::NUM_AXES; a++) begin : g_axis
      for (genvar b = 0; b < alarm_pkg::NUM_BANDS; b++) begin : g_band
         alarm_band_eval u_band (
            .mclk(mclk),
            .rst_n(rst_n),
            .restart(band_restart),
            .enable(alarm_control_register[a]),
            .record_start(record_start),
            .record_end(record_end),
            .bin_hit(rate_ok && bin_axis == 1'(a)),
            .bin_index(bin_index),
            .bin_mag(bin_mag),
            .low_bin(band_low_bins[b*8 +: 8]),
            .high_bin(band_high_bins[b*8 +: 8]),
            .warn_level(a == 0 ? x_warning_trigger_level : y_warning_trigger_level),
            .crit_level(a == 0 ? x_critical_trigger_level : y_critical_trigger_level),
            .delay(alarm_control_register[alarm_pkg::CTRL_DELAY_HI:alarm_pkg::CTRL_DELAY_LO]),
            .warn_flag(warn_flags[a][b]),
            .crit_flag(crit_flags[a][b])
         );
      end
   end

   // status words: band pairs and most critical band
   always_comb begin
      for (int a = 0; a < alarm_pkg::NUM_AXES; a++) begin
         next_status[a] = 16'h0000;
         for (int b = 0; b < alarm_pkg::NUM_BANDS; b++) begin
            next_status[a][alarm_pkg::STAT_BAND_BASE + 2*b] = warn_flags[a][b];
            next_status[a][alarm_pkg::STAT_BAND_BASE + 2*b + 1] = crit_flags[a][b];
         end
         for (int b = alarm_pkg::NUM_BANDS - 1; b >= 0; b--) begin
            if (warn_flags[a][b] && !(|crit_flags[a])) begin
               next_status[a][2:0] = 3'(b + 1);
            end
         end
         for (int b = alarm_pkg::NUM_BANDS - 1; b >= 0; b--) begin
            if (crit_flags[a][b]) begin
               next_status[a][2:0] = 3'(b + 1);
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         x_band_alarm_status <= 16'h0000;
         y_band_alarm_status <= 16'h0000;
      end else begin
         x_band_alarm_status <= next_status[0];
         y_band_alarm_status <= next_status[1];
      end
   end

   // strongest content per axis over a record
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         run_valid <= 2'b00;
         for (int a = 0; a < 2; a++) begin
            run_peak[a] <= 16'h0000;
            run_bin[a] <= 8'h00;
         end
      end else if (record_start || clear_cmd) begin
         run_valid <= 2'b00;
         for (int a = 0; a < 2; a++) begin
            run_peak[a] <= 16'h0000;
            run_bin[a] <= 8'h00;
         end
      end else if (rate_ok && (!run_valid[bin_axis] || bin_mag > run_peak[bin_axis])) begin
         run_valid[bin_axis] <= 1'b1;
         run_peak[bin_axis] <= bin_mag;
         run_bin[bin_axis] <= bin_index;
      end
   end

   // header capture: peak at record end, strobe once status has settled
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         x_axis_peak_magnitude <= 16'h0000;
         y_axis_peak_magnitude <= 16'h0000;
         x_axis_peak_bin <= 8'h00;
         y_axis_peak_bin <= 8'h00;
         record_end_d <= 1'b0;
         header_strobe <= 1'b0;
      end else begin
         record_end_d <= record_end && !clear_cmd;
         header_strobe <= record_end_d;
         if (clear_cmd) begin
            x_axis_peak_magnitude <= 16'h0000;
            y_axis_peak_magnitude <= 16'h0000;
            x_axis_peak_bin <= 8'h00;
            y_axis_peak_bin <= 8'h00;
         end else if (record_end) begin
            x_axis_peak_magnitude <= run_peak[0];
            y_axis_peak_magnitude <= run_peak[1];
            x_axis_peak_bin <= run_bin[0];
            y_axis_peak_bin <= run_bin[1];
         end
      end
   end

   // system alarm on temperature or supply, above or below the level
   assign sys_meas = alarm_control_register[alarm_pkg::CTRL_SYS_TEMP] ?
                     temperature : supply_voltage;
   assign sys_trip = alarm_control_register[alarm_pkg::CTRL_SYS_BELOW] ?
                     (sys_meas < system_trigger_level) :
                     (sys_meas > system_trigger_level);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sys_live <= 1'b0;
      end else if (!alarm_control_register[alarm_pkg::CTRL_SYS_EN]) begin
         sys_live <= 1'b0;
      end else if (meas_valid) begin
         sys_live <= sys_trip;
      end
   end

   // diagnostic flags, live or latched; a new event beats clear-status
   always_comb begin
      diag_event = 4'h0;
      diag_event[alarm_pkg::DIAG_SYS] = sys_live;
      diag_event[alarm_pkg::DIAG_X_SPECTRAL] = |x_band_alarm_status[15:4];
      diag_event[alarm_pkg::DIAG_Y_SPECTRAL] = |y_band_alarm_status[15:4];
      diag_event[alarm_pkg::DIAG_SAVE_DROPPED] = save_cmd && !clear_cmd && storage_written;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         diagnostic_error_flags <= 4'h0;
      end else if (alarm_control_register[alarm_pkg::CTRL_LATCH]) begin
         diagnostic_error_flags <= diag_event |
            (clear_status_cmd ? 4'h0 : diagnostic_error_flags);
      end else begin
         diagnostic_error_flags <= diag_event;
      end
   end

   // alarm indicator outputs
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         first_digital_output <= 1'b0;
         second_digital_output <= 1'b0;
      end else begin
         first_digital_output <= alarm_control_register[alarm_pkg::CTRL_DO_ALARM] &&
            output_select_control[alarm_pkg::SEL_DO1_ALARM] &&
            (|warn_flags[0] || |warn_flags[1]);
         second_digital_output <= alarm_control_register[alarm_pkg::CTRL_DO_ALARM] &&
            output_select_control[alarm_pkg::SEL_DO2_ALARM] &&
            (|crit_flags[0] || |crit_flags[1]);
      end
   end

   // register read port
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 16'h0000;
      end else begin
         unique case (reg_addr)
            alarm_pkg::ADDR_X_WARN: reg_rdata <= x_warning_trigger_level;
            alarm_pkg::ADDR_Y_WARN: reg_rdata <= y_warning_trigger_level;
            alarm_pkg::ADDR_X_CRIT: reg_rdata <= x_critical_trigger_level;
            alarm_pkg::ADDR_Y_CRIT: reg_rdata <= y_critical_trigger_level;
            alarm_pkg::ADDR_SYS_LEVEL: reg_rdata <= system_trigger_level;
            alarm_pkg::ADDR_ALARM_CTRL: reg_rdata <= alarm_control_register;
            alarm_pkg::ADDR_DIAG: reg_rdata <= {12'h000, diagnostic_error_flags};
            alarm_pkg::ADDR_X_STATUS: reg_rdata <= x_band_alarm_status;
            alarm_pkg::ADDR_Y_STATUS: reg_rdata <= y_band_alarm_status;
            alarm_pkg::ADDR_X_PEAK: reg_rdata <= x_axis_peak_magnitude;
            alarm_pkg::ADDR_Y_PEAK: reg_rdata <= y_axis_peak_magnitude;
            alarm_pkg::ADDR_X_BIN: reg_rdata <= {8'h00, x_axis_peak_bin};
            alarm_pkg::ADDR_Y_BIN: reg_rdata <= {8'h00, y_axis_peak_bin};
            alarm_pkg::ADDR_OUT_SELECT: reg_rdata <= {10'h000, output_select_control};
            default: reg_rdata <= 16'h0000;
         endcase
      end
   end

   // checks
   a_level_write: assert property (@(posedge mclk) disable iff (!rst_n)
      reg_wr && reg_addr == alarm_pkg::ADDR_X_CRIT && !clear_cmd |=> ##1
      reg_rdata == $past(reg_wdata, 2) || $past(reg_addr) != alarm_pkg::ADDR_X_CRIT)
      else $error("critical level write not kept");
   a_clear_erase: assert property (@(posedge mclk) disable iff (!rst_n)
      clear_cmd |=> x_warning_trigger_level == 16'h0000 && y_critical_trigger_level == 16'h0000)
      else $error("clear left trigger levels");
   a_save_issue: assert property (@(posedge mclk) disable iff (!rst_n)
      save_cmd && !clear_cmd && !storage_written |=> save_request ##1 storage_written)
      else $error("save not issued");
   a_save_drop: assert property (@(posedge mclk) disable iff (!rst_n)
      save_cmd && storage_written |=> !save_request)
      else $error("save issued twice");
   a_do_disabled: assert property (@(posedge mclk) disable iff (!rst_n)
      !alarm_control_register[alarm_pkg::CTRL_DO_ALARM] |=>
      !first_digital_output && !second_digital_output)
      else $error("alarm outputs driven while disabled");
   a_status_pair: assert property (@(posedge mclk) disable iff (!rst_n)
      1'b1 |=> x_band_alarm_status[5] == $past(crit_flags[0][0]) &&
      y_band_alarm_status[14] == $past(warn_flags[1][5]))
      else $error("band pair misplaced");
   a_most_band: assert property (@(posedge mclk) disable iff (!rst_n)
      !x_band_alarm_status[3] && x_band_alarm_status[2:0] <= 3'h6 &&
      ((x_band_alarm_status[2:0] == 3'h0) == (x_band_alarm_status[15:4] == 12'h000)))
      else $error("most critical band field wrong");
   a_rate_ignore: assert property (@(posedge mclk) disable iff (!rst_n)
      bin_valid && bin_rate != active_rate && !record_start && !clear_cmd |=>
      $stable(run_peak[0]) && $stable(run_peak[1]))
      else $error("inactive rate bin used");
   a_sys_above: assert property (@(posedge mclk) disable iff (!rst_n)
      meas_valid && alarm_control_register[5:3] == 3'b011 &&
      temperature > system_trigger_level |=> sys_live ##1
      diagnostic_error_flags[alarm_pkg::DIAG_SYS])
      else $error("system alarm missed");
   a_latch_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      alarm_control_register[alarm_pkg::CTRL_LATCH] && !clear_status_cmd &&
      diagnostic_error_flags[alarm_pkg::DIAG_SYS] |=> diagnostic_error_flags[alarm_pkg::DIAG_SYS])
      else $error("latched flag dropped");
endmodule

// *** bench/host_model.sv ***
// host-side model driving the register port of the alarm block
`timescale 1ns/1ps
module host_model (
   input wire logic mclk,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 16'h0000;
   end
   // one-cycle strobe; data line shows the inverse once released
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk) #1;
      reg_addr = a;
      reg_wr = 1'b1;
      reg_wdata = d;
      @(posedge mclk) #1;
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge mclk) #1;
      reg_addr = a;
      @(posedge mclk) #1;
      d = reg_rdata;
   endtask
   // critical level written as warning level plus one, which wraps to 0 when the warning level is 16'hffff
   task automatic set_levels(input logic [7:0] wa, input logic [7:0] ca, input logic [15:0] w);
      wr(wa, w);
      wr(ca, w + 16'h0001);
   endtask
   task automatic command(input int bit_pos);
      wr(alarm_pkg::ADDR_GLOBAL_CMD, 16'h0001 << bit_pos);
   endtask
   task automatic pick_outputs(input logic [5:0] sel);
      wr(alarm_pkg::ADDR_OUT_SELECT, {10'h000, sel});
   endtask
endmodule

// *** bench/spectral_alarm_trigger_status_tb.sv ***
// self-checking bench for the spectral alarm trigger and status block
`timescale 1ns/1ps
module spectral_alarm_trigger_status_tb;
   logic mclk, rst_n, reg_wr, record_start, record_end, bin_valid, bin_axis, meas_valid;
   logic [7:0] reg_addr, bin_index;
   logic [15:0] reg_wdata, reg_rdata, bin_mag, temperature, rv, x_stat, y_stat;
   logic [1:0] bin_rate, rec_range;
   logic [47:0] low_bins, high_bins;
   logic first_out, second_out, save_request, header_strobe;
   logic [3:0] diag;
   int n_fail = 0;
   int n_tests = 0;
   int n_saves = 0;
   host_model host_u (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   spectral_alarm_trigger_status dut_u (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .record_mode(2'h0), .record_range(rec_range),
      .active_rate(2'h1), .band_low_bins(low_bins), .band_high_bins(high_bins),
      .record_start(record_start), .record_end(record_end), .bin_valid(bin_valid),
      .bin_axis(bin_axis), .bin_rate(bin_rate), .bin_index(bin_index), .bin_mag(bin_mag),
      .meas_valid(meas_valid), .temperature(temperature), .supply_voltage(16'h0010),
      .reg_rdata(reg_rdata), .first_digital_output(first_out),
      .second_digital_output(second_out), .save_request(save_request),
      .header_strobe(header_strobe), .diagnostic_error_flags(diag),
      .x_band_alarm_status(x_stat), .y_band_alarm_status(y_stat),
      .x_axis_peak_magnitude(), .y_axis_peak_magnitude(), .x_axis_peak_bin(),
      .y_axis_peak_bin());
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   always @(negedge mclk) if (save_request === 1'b1) n_saves++;
   task automatic finish_test();
      $display("compares %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
      host_u.rd(a, rv);
      chk(rv, exp);
   endtask
   // one system measurement sample, then wait for the diag flag
   task automatic sys_sample();
      @(posedge mclk) #1 meas_valid = 1'b1;
      @(posedge mclk) #1 meas_valid = 1'b0;
      repeat (2) @(posedge mclk) #1;
   endtask
   // band 1 on x hit, band 3 on y hit, a loud bin on the idle rate option
   task automatic rec();
      @(posedge mclk) #1 record_start = 1'b1;
      @(posedge mclk) #1 record_start = 1'b0;
      {bin_valid, bin_axis, bin_rate, bin_index, bin_mag} = {4'h9, 8'h0f, 16'h0200};
      @(posedge mclk) #1 {bin_axis, bin_index} = {1'b1, 8'h2d};
      @(posedge mclk) #1 {bin_rate, bin_index, bin_mag} = {2'h2, 8'h0c, 16'hffff};
      @(posedge mclk) #1 {bin_valid, record_end} = 2'h1;
      @(posedge mclk) #1 record_end = 1'b0;
      for (int i = 0; i < 20 && header_strobe !== 1'b1; i++) @(posedge mclk) #1;
      if (header_strobe !== 1'b1) begin
         n_fail++;
         finish_test();
      end
   endtask
   task automatic test_defaults();
      rd_chk(alarm_pkg::ADDR_X_WARN, 16'h0000);
      rd_chk(alarm_pkg::ADDR_Y_CRIT, 16'h0000);
      rd_chk(alarm_pkg::ADDR_ALARM_CTRL, 16'h0080);
      rd_chk(8'h02, 16'h0000);
      $display("defaults done");
   endtask
   task automatic test_bands();
      host_u.command(alarm_pkg::CMD_ALARM_CLEAR);
      host_u.set_levels(alarm_pkg::ADDR_X_WARN, alarm_pkg::ADDR_X_CRIT, 16'h0100);
      host_u.set_levels(alarm_pkg::ADDR_Y_WARN, alarm_pkg::ADDR_Y_CRIT, 16'h01ff);
      rd_chk(alarm_pkg::ADDR_Y_CRIT, 16'h0200);
      host_u.wr(alarm_pkg::ADDR_SYS_LEVEL, 16'h0064);
      host_u.wr(alarm_pkg::ADDR_ALARM_CTRL, 16'h00db);
      host_u.pick_outputs(6'h03);
      sys_sample();
      chk({15'h0000, diag[0]}, 16'h0001);
      rec();
      chk(x_stat, 16'h0031);
      chk(y_stat, 16'h0103);
      chk({14'h0000, second_out, first_out}, 16'h0003);
      rd_chk(alarm_pkg::ADDR_Y_STATUS, 16'h0103);
      rd_chk(alarm_pkg::ADDR_X_PEAK, 16'h0200);
      rd_chk(alarm_pkg::ADDR_Y_BIN, 16'h002d);
      $display("bands done");
   endtask
   task automatic test_save();
      host_u.command(alarm_pkg::CMD_ALARM_SAVE);
      host_u.command(alarm_pkg::CMD_ALARM_SAVE);
      repeat (3) @(posedge mclk) #1;
      chk(16'(n_saves), 16'h0001);
      chk({15'h0000, diag[3]}, 16'h0001);
      host_u.command(alarm_pkg::CMD_CLEAR_STATUS);
      repeat (2) @(posedge mclk) #1;
      chk({12'h000, diag & 4'h9}, 16'h0001);
      host_u.command(alarm_pkg::CMD_ALARM_CLEAR);
      rd_chk(alarm_pkg::ADDR_X_CRIT, 16'h0000);
      $display("save done");
   endtask
   task automatic test_delay();
      host_u.set_levels(alarm_pkg::ADDR_X_WARN, alarm_pkg::ADDR_X_CRIT, 16'h0100);
      host_u.wr(alarm_pkg::ADDR_ALARM_CTRL, 16'h0143);
      rec();
      chk(x_stat, 16'h0000);
      rec();
      chk(x_stat, 16'h0031);
      rec_range = 2'h2;
      repeat (2) @(posedge mclk) #1;
      chk(x_stat, 16'h0000);
      $display("delay done");
   endtask
   task automatic test_system();
      host_u.wr(alarm_pkg::ADDR_ALARM_CTRL, 16'h0028);
      sys_sample();
      chk({15'h0000, diag[0]}, 16'h0001);
      host_u.wr(alarm_pkg::ADDR_ALARM_CTRL, 16'h0008);
      sys_sample();
      chk({15'h0000, diag[0]}, 16'h0000);
      $display("system done");
   endtask
   initial begin
      rst_n = 1'b0;
      {record_start, record_end, bin_valid, bin_axis, meas_valid} = 5'h00;
      rec_range = 2'h1;
      {bin_rate, bin_index, bin_mag, temperature} = {2'h1, 8'h00, 16'h0000, 16'h00c8};
      low_bins = 48'hc8c8_c828_c80a;
      high_bins = 48'hd2d2_d232_d214;
      repeat (5) @(posedge mclk);
      #1 rst_n = 1'b1;
      test_defaults();
      test_bands();
      test_save();
      test_delay();
      test_system();
      finish_test();
   end
endmodule
